//--- cpu_regs_pkg.sv
package cpu_regs_pkg;

  // Operations issued by the sequencer, one per enabled cycle
  typedef enum logic [4:0] {
    OP_NOP   = 5'h00,
    OP_ADD   = 5'h01,
    OP_ADC   = 5'h02,
    OP_SUB   = 5'h03,
    OP_SBC   = 5'h04,
    OP_AND   = 5'h05,
    OP_OR    = 5'h06,
    OP_XOR   = 5'h07,
    OP_LD    = 5'h08,
    OP_SHL   = 5'h09,
    OP_SHR   = 5'h0A,
    OP_ROL   = 5'h0B,
    OP_ROR   = 5'h0C,
    OP_BTST  = 5'h0D,
    OP_SCF   = 5'h0E,
    OP_RCF   = 5'h0F,
    OP_RIM   = 5'h10,
    OP_SIM   = 5'h11,
    OP_HALT  = 5'h12,
    OP_WFI   = 5'h13,
    OP_POPCC = 5'h14,
    OP_INTERRUPT_RETURN_INSTR  = 5'h15
  } op_t;

  // Branch conditions, H, N, Z and C each in both senses
  typedef enum logic [2:0] {
    BR_HALF    = 3'h0,
    BR_NO_HALF = 3'h1,
    BR_MINUS   = 3'h2,
    BR_PLUS    = 3'h3,
    BR_EQUAL   = 3'h4,
    BR_NEQUAL  = 3'h5,
    BR_CARRY   = 3'h6,
    BR_NCARRY  = 3'h7
  } cond_t;

  // Flag positions in condition_flags
  localparam int unsigned BIT_C  = 0;
  localparam int unsigned BIT_Z  = 1;
  localparam int unsigned BIT_N  = 2;
  localparam int unsigned BIT_I0 = 3;
  localparam int unsigned BIT_H  = 4;
  localparam int unsigned BIT_I1 = 5;

  // Reset and fixed values
  localparam logic [7:0] CC_RESET = 8'hE8;
  localparam logic [7:0] CC_FIXED = 8'hC0;
  localparam logic [7:0] SP_HIGH  = 8'h01;
  localparam logic [7:0] SP_RESET = 8'hFF;

  // Priority encodings {high, low}
  localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
  localparam logic [1:0] PRIO_LEVEL3 = 2'h3;

endpackage

//--- alu8.sv
`timescale 1ns/1ps
module alu8 (
  // Operation and operands
  input  wire cpu_regs_pkg::op_t op,
  input  wire logic [7:0]        a,
  input  wire logic [7:0]        b,
  input  wire logic              cin,
  // Results
  output logic [7:0]             res,
  output logic                   cout,
  output logic                   hout
);

  // One combinational stage; flags chosen by the caller
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    sum  = 9'h000;
    nib  = 5'h00;
    res  = b;
    cout = cin;
    hout = 1'b0;
    case (op)
      cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADC: begin
        sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin && op == cpu_regs_pkg::OP_ADC};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin && op == cpu_regs_pkg::OP_ADC};
        res  = sum[7:0];
        cout = sum[8];
        hout = nib[4];
      end
      cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SBC: begin
        // Borrow lands in bit 8
        sum  = {1'b0, a} - {1'b0, b} - {8'h00, cin && op == cpu_regs_pkg::OP_SBC};
        res  = sum[7:0];
        cout = sum[8];
      end
      cpu_regs_pkg::OP_AND: res = a & b;
      cpu_regs_pkg::OP_OR:  res = a | b;
      cpu_regs_pkg::OP_XOR: res = a ^ b;
      cpu_regs_pkg::OP_SHL: begin
        res  = {a[6:0], 1'b0};
        cout = a[7];
      end
      cpu_regs_pkg::OP_SHR: begin
        res  = {1'b0, a[7:1]};
        cout = a[0];
      end
      cpu_regs_pkg::OP_ROL: begin
        res  = {a[6:0], cin};
        cout = a[7];
      end
      cpu_regs_pkg::OP_ROR: begin
        res  = {cin, a[7:1]};
        cout = a[0];
      end
      default: res = b;
    endcase
  end

endmodule

//--- cpu_core_registers_and_flags.sv
// Overview of operation
// - Eight-bit accumulator feeds and receives ALU operations and data moves.
// - Two eight-bit index registers; the prefix input selects the second one.
// - Interrupt entry and return never change the second index register.
// - Sixteen-bit program counter built from separate low and high byte registers.
// - A sixteen-bit stack pointer sits beside the other registers.
// - Core registers have no memory address; only operations reach them.
// - Flags reset to 111x1xxx; bits 7 and 6 always read one.
// - Flags can be pushed, popped, and each bit tested or controlled.
// - Add operations set half-carry on carry from bit 3 into bit 4.
// - Negative flag copies bit 7 of the last result.
// - Zero flag is set when the last result is zero, else cleared.
// - Carry reflects overflow or borrow; bit test, shifts and rotates update it.
// - Set-carry and reset-carry operations force carry to one or zero.
// - Branch conditions test the H, N, Z and C flags in both senses.
// - Priority bits 5 and 3: 10 level 0, 01 level 1, 00 level 2, 11 off.
// - Interrupt entry loads priority bits from the serviced source's priority.
// - Enable, disable, return, halt, wait and flag pop also change priority.
`timescale 1ns/1ps
module cpu_core_registers_and_flags (
  // Clock, reset, enable
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                clk_en,
  // Operation issue
  input  wire logic                op_valid,
  input  wire cpu_regs_pkg::op_t   op_code,
  input  wire logic                dest_index,
  input  wire logic                index_prefix,
  input  wire logic [7:0]          operand,
  input  wire logic [2:0]          bit_sel,
  // Interrupt entry
  input  wire logic                int_entry,
  input  wire logic [1:0]          int_prio,
  // Program counter control
  input  wire logic                pc_step,
  input  wire logic                pc_load,
  input  wire logic [15:0]         pc_target,
  // Stack pointer control
  input  wire logic                sp_push,
  input  wire logic                sp_pop,
  input  wire logic                sp_reset,
  // Branch test
  input  wire cpu_regs_pkg::cond_t branch_cond,
  output logic                     branch_taken,
  // Register views
  output logic [7:0]               accumulator,
  output logic [7:0]               index_x,
  output logic [7:0]               index_y,
  output logic [15:0]              program_counter,
  output logic [15:0]              stack_pointer,
  output logic [7:0]               condition_flags
);

  logic [7:0] acc_q, acc_d;
  logic [7:0] ix_q, ix_d;
  logic [7:0] iy_q, iy_d;
  logic [7:0] pcl_q, pcl_d;
  logic [7:0] pch_q, pch_d;
  logic [7:0] spl_q, spl_d;
  logic [7:0] cc_q, cc_d;
  logic [7:0] dst_val;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_h;
  logic       do_op;

  // Operations only count on enabled cycles; entry preempts them
  assign do_op = clk_en && op_valid && !int_entry;

  // Operand A is the addressed destination
  always_comb begin
    if (!dest_index) begin
      dst_val = acc_q;
    end else if (index_prefix) begin
      dst_val = iy_q;
    end else begin
      dst_val = ix_q;
    end
  end

  alu8 u_alu (
    .op   (op_code),
    .a    (dst_val),
    .b    (operand),
    .cin  (cc_q[cpu_regs_pkg::BIT_C]),
    .res  (alu_res),
    .cout (alu_c),
    .hout (alu_h)
  );

  // Data registers: no address decode exists, only operations write them
  always_comb begin
    logic wr;
    wr   = 1'b0;
    acc_d = acc_q;
    ix_d  = ix_q;
    iy_d  = iy_q;
    if (do_op) begin
      case (op_code)
        cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADC, cpu_regs_pkg::OP_SUB,
        cpu_regs_pkg::OP_SBC, cpu_regs_pkg::OP_AND, cpu_regs_pkg::OP_OR,
        cpu_regs_pkg::OP_XOR, cpu_regs_pkg::OP_LD, cpu_regs_pkg::OP_SHL,
        cpu_regs_pkg::OP_SHR, cpu_regs_pkg::OP_ROL,
        cpu_regs_pkg::OP_ROR: wr = 1'b1;
        default:               wr = 1'b0;
      endcase
    end
    // Return pops only flags here, so Y stays put
    if (wr && !dest_index) begin
      acc_d = alu_res;
    end else if (wr && index_prefix) begin
      iy_d = alu_res;
    end else if (wr) begin
      ix_d = alu_res;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 8'h00;
      ix_q  <= 8'h00;
      iy_q  <= 8'h00;
    end else if (clk_en) begin
      acc_q <= acc_d;
      ix_q  <= ix_d;
      iy_q  <= iy_d;
    end
  end

  // Program counter as two byte registers; load beats step
  always_comb begin
    logic [15:0] inc;
    inc   = {pch_q, pcl_q} + 16'h0001;
    pcl_d = pcl_q;
    pch_d = pch_q;
    if (pc_load) begin
      pcl_d = pc_target[7:0];
      pch_d = pc_target[15:8];
    end else if (pc_step) begin
      pcl_d = inc[7:0];
      pch_d = inc[15:8];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pcl_q <= 8'h00;
      pch_q <= 8'h00;
    end else if (clk_en) begin
      pcl_q <= pcl_d;
      pch_q <= pch_d;
    end
  end

  // Stack low byte wraps silently; high byte is hardwired
  always_comb begin
    spl_d = spl_q;
    if (sp_reset) begin
      spl_d = cpu_regs_pkg::SP_RESET;
    end else if (sp_push && !sp_pop) begin
      spl_d = spl_q - 8'h01;
    end else if (sp_pop && !sp_push) begin
      spl_d = spl_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      spl_q <= cpu_regs_pkg::SP_RESET;
    end else if (clk_en) begin
      spl_q <= spl_d;
    end
  end

  // Condition flags; untouched bits ride through from cc_q
  always_comb begin
    cc_d = cc_q;
    if (clk_en && int_entry) begin
      cc_d[cpu_regs_pkg::BIT_I1] = int_prio[1];
      cc_d[cpu_regs_pkg::BIT_I0] = int_prio[0];
    end else if (do_op) begin
      case (op_code)
        cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADC: begin
          cc_d[cpu_regs_pkg::BIT_H] = alu_h;
          cc_d[cpu_regs_pkg::BIT_N] = alu_res[7];
          cc_d[cpu_regs_pkg::BIT_Z] = alu_res == 8'h00;
          cc_d[cpu_regs_pkg::BIT_C] = alu_c;
        end
        cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SBC,
        cpu_regs_pkg::OP_SHL, cpu_regs_pkg::OP_SHR,
        cpu_regs_pkg::OP_ROL, cpu_regs_pkg::OP_ROR: begin
          cc_d[cpu_regs_pkg::BIT_N] = alu_res[7];
          cc_d[cpu_regs_pkg::BIT_Z] = alu_res == 8'h00;
          cc_d[cpu_regs_pkg::BIT_C] = alu_c;
        end
        cpu_regs_pkg::OP_AND, cpu_regs_pkg::OP_OR,
        cpu_regs_pkg::OP_XOR, cpu_regs_pkg::OP_LD: begin
          cc_d[cpu_regs_pkg::BIT_N] = alu_res[7];
          cc_d[cpu_regs_pkg::BIT_Z] = alu_res == 8'h00;
        end
        cpu_regs_pkg::OP_BTST: cc_d[cpu_regs_pkg::BIT_C] = operand[bit_sel];
        cpu_regs_pkg::OP_SCF:  cc_d[cpu_regs_pkg::BIT_C] = 1'b1;
        cpu_regs_pkg::OP_RCF:  cc_d[cpu_regs_pkg::BIT_C] = 1'b0;
        // Halt and wait re-enable interrupts at main level
        cpu_regs_pkg::OP_RIM, cpu_regs_pkg::OP_HALT, cpu_regs_pkg::OP_WFI: begin
          cc_d[cpu_regs_pkg::BIT_I1] = cpu_regs_pkg::PRIO_LEVEL0[1];
          cc_d[cpu_regs_pkg::BIT_I0] = cpu_regs_pkg::PRIO_LEVEL0[0];
        end
        cpu_regs_pkg::OP_SIM: begin
          cc_d[cpu_regs_pkg::BIT_I1] = cpu_regs_pkg::PRIO_LEVEL3[1];
          cc_d[cpu_regs_pkg::BIT_I0] = cpu_regs_pkg::PRIO_LEVEL3[0];
        end
        cpu_regs_pkg::OP_POPCC, cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR: cc_d = operand;
        default: cc_d = cc_q;
      endcase
    end
    cc_d = cc_d | cpu_regs_pkg::CC_FIXED;
  end

  // Undefined reset bits are given zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cc_q <= cpu_regs_pkg::CC_RESET;
    end else if (clk_en) begin
      cc_q <= cc_d;
    end
  end

  // Branch test is combinational so the sequencer can redirect at once
  always_comb begin
    case (branch_cond)
      cpu_regs_pkg::BR_HALF:    branch_taken = cc_q[cpu_regs_pkg::BIT_H];
      cpu_regs_pkg::BR_NO_HALF: branch_taken = !cc_q[cpu_regs_pkg::BIT_H];
      cpu_regs_pkg::BR_MINUS:   branch_taken = cc_q[cpu_regs_pkg::BIT_N];
      cpu_regs_pkg::BR_PLUS:    branch_taken = !cc_q[cpu_regs_pkg::BIT_N];
      cpu_regs_pkg::BR_EQUAL:   branch_taken = cc_q[cpu_regs_pkg::BIT_Z];
      cpu_regs_pkg::BR_NEQUAL:  branch_taken = !cc_q[cpu_regs_pkg::BIT_Z];
      cpu_regs_pkg::BR_CARRY:   branch_taken = cc_q[cpu_regs_pkg::BIT_C];
      default:                  branch_taken = !cc_q[cpu_regs_pkg::BIT_C];
    endcase
  end

  // Register views straight from flip-flops, except the hardwired stack high byte
  assign accumulator     = acc_q;
  assign index_x         = ix_q;
  assign index_y         = iy_q;
  assign program_counter = {pch_q, pcl_q};
  assign stack_pointer   = {cpu_regs_pkg::SP_HIGH, spl_q};
  assign condition_flags = cc_q;

  // Checks
  logic is_add;
  logic nib_carry;
  logic xor_zero;
  assign is_add    = do_op && (op_code == cpu_regs_pkg::OP_ADD);
  assign nib_carry = ({1'b0, dst_val[3:0]} + {1'b0, operand[3:0]}) > 5'h0F;
  // Own reckoning of the xor result, so any destination is covered
  assign xor_zero  = (dst_val ^ operand) == 8'h00;

  sequence s_entry;
    clk_en && int_entry;
  endsequence

  sequence s_ctx;
    s_entry or (do_op && op_code == cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR);
  endsequence

  property p_fixed;
    @(posedge clk_sys) disable iff (!arst_n)
    condition_flags[7:6] == 2'b11;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed flag bits not one");

  property p_half;
    @(posedge clk_sys) disable iff (!arst_n)
    is_add |=> cc_q[cpu_regs_pkg::BIT_H] == $past(nib_carry);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong after add");

  property p_neg;
    @(posedge clk_sys) disable iff (!arst_n)
    (do_op && op_code == cpu_regs_pkg::OP_LD) |=> cc_q[cpu_regs_pkg::BIT_N] == $past(operand[7]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag not result bit 7");

  property p_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    (do_op && op_code == cpu_regs_pkg::OP_XOR) |=> cc_q[cpu_regs_pkg::BIT_Z] == $past(xor_zero);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong after xor");

  property p_scf;
    @(posedge clk_sys) disable iff (!arst_n)
    (do_op && op_code == cpu_regs_pkg::OP_SCF) |=> cc_q[cpu_regs_pkg::BIT_C] ##1 1'b1;
  endproperty
  a_scf: assert property (p_scf) else $error("set carry did not set carry");

  property p_ykeep;
    @(posedge clk_sys) disable iff (!arst_n)
    s_ctx |=> $stable(iy_q);
  endproperty
  a_ykeep: assert property (p_ykeep) else $error("second index changed by interrupt context");

  property p_entry;
    @(posedge clk_sys) disable iff (!arst_n)
    s_entry |=> {cc_q[cpu_regs_pkg::BIT_I1], cc_q[cpu_regs_pkg::BIT_I0]} == $past(int_prio);
  endproperty
  a_entry: assert property (p_entry) else $error("entry priority not loaded");

  property p_sim;
    @(posedge clk_sys) disable iff (!arst_n)
    (do_op && op_code == cpu_regs_pkg::OP_SIM) |=> {cc_q[5], cc_q[3]} == 2'b11;
  endproperty
  a_sim: assert property (p_sim) else $error("disable did not reach level 3");

  property p_keep;
    @(posedge clk_sys) disable iff (!arst_n)
    (do_op && op_code == cpu_regs_pkg::OP_AND) |=> $stable(cc_q[cpu_regs_pkg::BIT_C])
      && $stable(cc_q[cpu_regs_pkg::BIT_H]);
  endproperty
  a_keep: assert property (p_keep) else $error("logic op touched carry or half");

endmodule

//--- test_cpu_core_registers_and_flags.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; $display("Error %0t: mismatch got %h expected %h", $time, got, exp); end end

module test_cpu_core_registers_and_flags;
  // One table row: operation, target select, operand, bit, expected acc and flags
  typedef struct {
    cpu_regs_pkg::op_t op;
    logic [1:0]        sel;
    logic [7:0]        opd;
    logic [2:0]        bsel;
    logic [7:0]        acc;
    logic [7:0]        cc;
  } row_t;

  logic                clk_sys;
  logic                arst_n;
  logic                clk_en;
  logic                op_valid;
  cpu_regs_pkg::op_t   op_code;
  logic                dest_index;
  logic                index_prefix;
  logic [7:0]          operand;
  logic [2:0]          bit_sel;
  logic                int_entry;
  logic [1:0]          int_prio;
  logic                pc_step;
  logic                pc_load;
  logic [15:0]         pc_target;
  logic                sp_push;
  logic                sp_pop;
  logic                sp_reset;
  cpu_regs_pkg::cond_t branch_cond;
  logic                branch_taken;
  logic [7:0]          accumulator;
  logic [7:0]          index_x;
  logic [7:0]          index_y;
  logic [15:0]         program_counter;
  logic [15:0]         stack_pointer;
  logic [7:0]          condition_flags;
  int                  err_count;
  int                  tests_run;
  row_t                rows [27];
  logic [7:0]          cc_exp;
  // Stack strobes {push,pop,reset}; both push and pop together must cancel
  logic [2:0]          sp_ops [7] = '{3'h4, 3'h2, 3'h2, 3'h6, 3'h4, 3'h4, 3'h5};
  logic [15:0]         sp_exp [7] = '{16'h01FE, 16'h01FF, 16'h0100, 16'h0100, 16'h01FF, 16'h01FE, 16'h01FF};

  cpu_core_registers_and_flags DUT (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .clk_en          (clk_en),
    .op_valid        (op_valid),
    .op_code         (op_code),
    .dest_index      (dest_index),
    .index_prefix    (index_prefix),
    .operand         (operand),
    .bit_sel         (bit_sel),
    .int_entry       (int_entry),
    .int_prio        (int_prio),
    .pc_step         (pc_step),
    .pc_load         (pc_load),
    .pc_target       (pc_target),
    .sp_push         (sp_push),
    .sp_pop          (sp_pop),
    .sp_reset        (sp_reset),
    .branch_cond     (branch_cond),
    .branch_taken    (branch_taken),
    .accumulator     (accumulator),
    .index_x         (index_x),
    .index_y         (index_y),
    .program_counter (program_counter),
    .stack_pointer   (stack_pointer),
    .condition_flags (condition_flags)
  );

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task finish_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Strobes drop on the taking edge, so each request lives exactly one cycle
  task settle;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    int_entry <= 1'b0;
    pc_step <= 1'b0;
    pc_load <= 1'b0;
    {sp_push, sp_pop, sp_reset} <= 3'h0;
    #1;
  endtask

  task check_reset;
    `CHK(accumulator, 8'h00)
    `CHK(index_x, 8'h00)
    `CHK(index_y, 8'h00)
    `CHK(program_counter, 16'h0000)
    `CHK(stack_pointer, 16'h01FF)
    `CHK(condition_flags, 8'hE8)
  endtask

  // Every condition in both senses against a known flag byte
  task check_branches(input logic [7:0] cc);
    logic [3:0] f;
    f = {cc[cpu_regs_pkg::BIT_C], cc[cpu_regs_pkg::BIT_Z], cc[cpu_regs_pkg::BIT_N], cc[cpu_regs_pkg::BIT_H]};
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys);
      branch_cond <= cpu_regs_pkg::cond_t'(c[2:0]);
      #1;
      `CHK(branch_taken, f[c / 2] ^ c[0])
    end
  endtask

  // Watchdog, far beyond the roughly 120 cycles the run needs
  initial begin
    #250000;
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    {arst_n, op_valid, dest_index, index_prefix, int_entry, pc_step, pc_load} = 7'h00;
    {sp_push, sp_pop, sp_reset, clk_en} = 4'h1;
    op_code = cpu_regs_pkg::OP_NOP;
    operand = 8'h00;
    bit_sel = 3'h0;
    int_prio = 2'h0;
    pc_target = 16'h0000;
    branch_cond = cpu_regs_pkg::BR_HALF;
    rows = '{
      '{cpu_regs_pkg::OP_LD, 2'h0, 8'h03, 3'h0, 8'h03, 8'hE8}, '{cpu_regs_pkg::OP_ADD, 2'h0, 8'h05, 3'h0, 8'h08, 8'hE8},
      '{cpu_regs_pkg::OP_ADD, 2'h0, 8'h08, 3'h0, 8'h10, 8'hF8}, '{cpu_regs_pkg::OP_ADD, 2'h0, 8'hF0, 3'h0, 8'h00, 8'hEB},
      '{cpu_regs_pkg::OP_ADC, 2'h0, 8'h7F, 3'h0, 8'h80, 8'hFC}, '{cpu_regs_pkg::OP_SUB, 2'h0, 8'h81, 3'h0, 8'hFF, 8'hFD},
      '{cpu_regs_pkg::OP_SBC, 2'h0, 8'h0F, 3'h0, 8'hEF, 8'hFC}, '{cpu_regs_pkg::OP_AND, 2'h0, 8'h0F, 3'h0, 8'h0F, 8'hF8},
      '{cpu_regs_pkg::OP_XOR, 2'h0, 8'h0F, 3'h0, 8'h00, 8'hFA}, '{cpu_regs_pkg::OP_OR, 2'h0, 8'h81, 3'h0, 8'h81, 8'hFC},
      '{cpu_regs_pkg::OP_SHL, 2'h0, 8'h00, 3'h0, 8'h02, 8'hF9}, '{cpu_regs_pkg::OP_ROL, 2'h0, 8'h00, 3'h0, 8'h05, 8'hF8},
      '{cpu_regs_pkg::OP_ROR, 2'h0, 8'h00, 3'h0, 8'h02, 8'hF9}, '{cpu_regs_pkg::OP_SHR, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF8},
      '{cpu_regs_pkg::OP_SCF, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF9}, '{cpu_regs_pkg::OP_RCF, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF8},
      '{cpu_regs_pkg::OP_BTST, 2'h0, 8'h80, 3'h7, 8'h01, 8'hF9}, '{cpu_regs_pkg::OP_RIM, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF1},
      '{cpu_regs_pkg::OP_SIM, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF9}, '{cpu_regs_pkg::OP_HALT, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF1},
      '{cpu_regs_pkg::OP_SIM, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF9}, '{cpu_regs_pkg::OP_WFI, 2'h0, 8'h00, 3'h0, 8'h01, 8'hF1},
      '{cpu_regs_pkg::OP_POPCC, 2'h0, 8'h00, 3'h0, 8'h01, 8'hC0}, '{cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR, 2'h0, 8'h2D, 3'h0, 8'h01, 8'hED},
      '{cpu_regs_pkg::OP_LD, 2'h2, 8'h5A, 3'h0, 8'h01, 8'hE9}, '{cpu_regs_pkg::OP_LD, 2'h3, 8'h00, 3'h0, 8'h01, 8'hEB},
      '{cpu_regs_pkg::OP_NOP, 2'h0, 8'h00, 3'h0, 8'h01, 8'hEB}};
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    check_reset();
    // Table: each row is one operation, with an idle cycle between rows
    foreach (rows[i]) begin
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_code <= rows[i].op;
      {dest_index, index_prefix} <= rows[i].sel;
      operand <= rows[i].opd;
      bit_sel <= rows[i].bsel;
      settle();
      `CHK(accumulator, rows[i].acc)
      `CHK(condition_flags, rows[i].cc)
    end
    `CHK(index_x, 8'h5A)
    `CHK(index_y, 8'h00)
    check_branches(8'hEB);
    // Entry with a same-cycle load to the second index: entry wins
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys);
      int_entry <= 1'b1;
      int_prio <= p[1:0];
      op_valid <= 1'b1;
      op_code <= cpu_regs_pkg::OP_LD;
      {dest_index, index_prefix} <= 2'h3;
      operand <= 8'h77;
      settle();
      cc_exp = (8'hEB & 8'hD7) | {2'h0, p[1], 1'b0, p[0], 3'h0};
      `CHK(condition_flags, cc_exp)
      `CHK(index_y, 8'h00)
    end
    // Frozen cycle: nothing may move
    @(posedge clk_sys);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    op_code <= cpu_regs_pkg::OP_ADD;
    {dest_index, index_prefix} <= 2'h0;
    operand <= 8'h01;
    pc_step <= 1'b1;
    settle();
    `CHK(accumulator, 8'h01)
    `CHK(program_counter, 16'h0000)
    @(posedge clk_sys);
    clk_en <= 1'b1;
    op_valid <= 1'b1;
    op_code <= cpu_regs_pkg::OP_POPCC;
    operand <= 8'h14;
    settle();
    `CHK(condition_flags, 8'hD4)
    check_branches(8'hD4);
    // Load beats step, then a step carries into the high byte
    @(posedge clk_sys);
    pc_load <= 1'b1;
    pc_step <= 1'b1;
    pc_target <= 16'h12FF;
    settle();
    `CHK(program_counter, 16'h12FF)
    @(posedge clk_sys);
    pc_step <= 1'b1;
    settle();
    `CHK(program_counter, 16'h1300)
    foreach (sp_ops[i]) begin
      @(posedge clk_sys);
      {sp_push, sp_pop, sp_reset} <= sp_ops[i];
      settle();
      `CHK(stack_pointer, sp_exp[i])
    end
    // Second reset in mid-run, then release and a first operation
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_reset();
    @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    check_reset();
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= cpu_regs_pkg::OP_LD;
    {dest_index, index_prefix} <= 2'h0;
    operand <= 8'h42;
    settle();
    `CHK(accumulator, 8'h42)
    `CHK(condition_flags, 8'hE8)
    finish_test();
  end
endmodule
